// [ihd_host.sv]
// main-side host controller driving an isolated half-duplex channel pair
// Function
// - only the main controller changes channel direction; secondaries never do.
// - requester sends bus request over direction channel, waits for acknowledge.
// - outputs enabled and transfer starts only when the two requests differ.
// - mains share one 8-bit bus, send command, address and data packets.
// - secondaries watch both requests, decode packets, reply only when addressed.
`timescale 1ns/1ps
module ihd_host
  import ihd_pkg::*;
#(
  parameter int STARTUP_WAIT = ihd_pkg::STARTUP_CYCLES,
  parameter int SETTLE_WAIT = ihd_pkg::PROP_CYCLES,
  parameter bit INVERTING = 1'b0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire ihd_pkg::ihd_word_t tx_word,
  output ihd_pkg::ihd_word_t rx_word,
  output logic rx_valid,
  output logic busy,
  output logic link_ready,
  output logic bus_req_local,
  input wire logic bus_req_remote,
  output ihd_pkg::ihd_pins_t pins,
  input wire logic [3:0] chan_a_in
);
  import ihd_pkg::*;

  function automatic logic [3:0] pol(input logic [3:0] v);
    pol = INVERTING ? ~v : v;
  endfunction : pol

  ihd_state_t state_q;
  ihd_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic req_q;
  logic nib_q;
  logic [3:0] rx_lo_q;
  logic rx_nib_q;
  ihd_word_t rx_q;
  logic rx_v_q;
  ihd_pins_t pins_q;
  logic fifo_valid;
  logic fifo_take;
  ihd_word_t fifo_word;

  // channel calm detector: a nibble is only taken once every lane has been
  // steady for the deglitch time before the sample edge, so short noise pulses reach rx data only when one lands on that edge
  logic [3:0] chan_prev_q;
  logic [7:0] calm_q;
  logic [7:0] calm_d;
  wire chan_same = (chan_a_in == chan_prev_q);
  wire calm = (calm_q >= 8'(DEGLITCH_CYCLES));
  assign calm_d = !chan_same ? 8'h00 : (calm_q == 8'hff) ? calm_q : calm_q + 8'h01;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_prev_q <= 4'h0;
      calm_q <= 8'h00;
    end else begin
      chan_prev_q <= chan_a_in;
      calm_q <= calm_d;
    end
  end

  // outgoing words queue here while the far host holds the channel;
  // a full queue pushes back on the producer instead of dropping words
  ihd_fifo #(
    .WIDTH($bits(ihd_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_word)
  );

  // agreement: our request and the far request differ
  wire agree = req_q ^ bus_req_remote;
  wire cnt_done = (cnt_q == 32'h0);
  wire remote_wants = bus_req_remote && !req_q;
  // a word leaves as two nibbles, low first; the fifo pops after the high one
  assign fifo_take = (state_q == IHD_XFER) && nib_q && cnt_done;
  wire [3:0] nib_out = nib_q ? fifo_word.data[7:4] : fifo_word.data[3:0];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 32'h1;
    case (state_q)
      IHD_BOOT: begin
        if (cnt_done) begin
          state_d = IHD_IDLE;
        end
      end
      IHD_IDLE: begin
        if (remote_wants) begin
          state_d = IHD_RECV;
          cnt_d = 32'(SETTLE_WAIT);
        end else if (fifo_valid) begin
          state_d = IHD_REQ;
        end
      end
      IHD_REQ: begin
        if (agree) begin
          state_d = IHD_XFER;
          cnt_d = 32'(SETTLE_WAIT);
        end
      end
      IHD_XFER: begin
        // each nibble waits the channel delay so the far side samples settled data
        if (cnt_done) begin
          cnt_d = 32'(SETTLE_WAIT);
          if (nib_q && fifo_word.last) begin
            state_d = IHD_HOLD;
          end
        end
      end
      IHD_HOLD: begin
        state_d = IHD_IDLE;
      end
      IHD_RECV: begin
        // a noisy lane defers the sample until it has been calm long enough
        if (!bus_req_remote) begin
          state_d = IHD_IDLE;
        end else if (cnt_done && calm) begin
          cnt_d = 32'(SETTLE_WAIT);
        end
      end
      default: begin
        state_d = IHD_BOOT;
      end
    endcase
  end

  wire drive_a = (state_q == IHD_XFER);
  wire recv_a = (state_q == IHD_RECV);
  wire sample = recv_a && cnt_done && bus_req_remote && calm;

  // the startup counter is reused afterwards for the per-nibble settle wait
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IHD_BOOT;
      cnt_q <= 32'(STARTUP_WAIT);
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= 1'b0;
      nib_q <= 1'b0;
    end else begin
      // only this main moves the direction line; the far host only raises its request
      req_q <= (state_d == IHD_REQ) || (state_d == IHD_XFER);
      if (state_q != IHD_XFER) begin
        nib_q <= 1'b0;
      end else if (cnt_done) begin
        nib_q <= ~nib_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_q.out_a <= 4'h0;
      pins_q.oe_a_n <= 4'hf;
      pins_q.dir <= 1'b0;
      pins_q.en_a <= 1'b0;
      pins_q.en_b <= 1'b0;
    end else begin
      pins_q.dir <= req_q;
      pins_q.en_a <= drive_a || recv_a;
      pins_q.en_b <= drive_a || recv_a;
      pins_q.out_a <= drive_a ? pol(nib_out) : 4'h0;
      pins_q.oe_a_n <= drive_a ? 4'h0 : 4'hf;
    end
  end

  // an odd nibble is dropped when the far request falls before its pair arrives
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_lo_q <= 4'h0;
      rx_nib_q <= 1'b0;
      rx_q <= '0;
      rx_v_q <= 1'b0;
    end else begin
      rx_v_q <= 1'b0;
      if (!recv_a) begin
        rx_nib_q <= 1'b0;
      end else if (sample) begin
        rx_nib_q <= ~rx_nib_q;
        if (!rx_nib_q) begin
          rx_lo_q <= pol(chan_a_in);
        end else begin
          rx_q.data <= {pol(chan_a_in), rx_lo_q};
          rx_q.last <= 1'b0;
          rx_v_q <= 1'b1;
        end
      end
    end
  end

  assign pins = pins_q;
  assign bus_req_local = req_q;
  assign rx_word = rx_q;
  assign rx_valid = rx_v_q;
  assign busy = (state_q != IHD_IDLE);
  assign link_ready = (state_q != IHD_BOOT);
endmodule : ihd_host

// [ihd_pkg.sv]
// package for the half-duplex host controller of the isolated reversible channels
package ihd_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STARTUP_US = 300;
  localparam int STARTUP_CYCLES = (STARTUP_US * 1000000) / CLK_PERIOD_PS;
  localparam int DEGLITCH_NS = 30;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROP_NS = 36;
  localparam int PROP_CYCLES = (PROP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LANES = 4;
  localparam int BUS_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    IHD_BOOT = 3'b000,
    IHD_IDLE = 3'b001,
    IHD_REQ = 3'b011,
    IHD_XFER = 3'b010,
    IHD_HOLD = 3'b110,
    IHD_RECV = 3'b111
  } ihd_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } ihd_word_t;

  typedef struct packed {
    logic [3:0] out_a;
    logic [3:0] oe_a_n;
    logic dir;
    logic en_a;
    logic en_b;
  } ihd_pins_t;
endpackage : ihd_pkg

// [ihd_fifo.sv]
// small synchronous fifo for outgoing packet words
`timescale 1ns/1ps
module ihd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_d;
  logic [WIDTH-1:0] out_q;
  logic out_v_q;
  wire empty = (wr_q == rd_q);
  // the output register counts as a slot, so at most DEPTH words are held in all
  wire [AW+1:0] held = {1'b0, wr_q - rd_q} + {{(AW+1){1'b0}}, out_v_q};
  wire full = (held >= (AW+2)'(DEPTH));
  wire push = in_valid && !full;
  // output stage is a register; refill it whenever it is empty or being taken
  wire load = !empty && (!out_v_q || out_ready);
  assign in_ready = !full;
  assign out_valid = out_v_q;
  assign out_data = out_q;
  assign wr_d = push ? wr_q + 1'b1 : wr_q;
  assign rd_d = load ? rd_q + 1'b1 : rd_q;
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      out_q <= '0;
      out_v_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      if (load) begin
        out_q <= mem_q[rd_q[AW-1:0]];
      end
      if (load) begin
        out_v_q <= 1'b1;
      end else if (out_ready) begin
        out_v_q <= 1'b0;
      end
    end
  end
endmodule : ihd_fifo

// [ihd_assertions.sv]
// checker for the half-duplex host ports
`timescale 1ns/1ps
module ihd_assertions
  import ihd_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire ihd_pkg::ihd_word_t rx_word,
  input wire logic link_ready,
  input wire logic bus_req_local,
  input wire logic bus_req_remote,
  input wire ihd_pkg::ihd_pins_t pins
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_en_agree: assert property (
    $rose(pins.en_b) |-> $past(bus_req_local ^ bus_req_remote)) else $error("enable no agree");
  chk_dir_own: assert property (
    $rose(pins.dir) |-> bus_req_local && !bus_req_remote) else $error("dir without request");
  chk_drive_dir: assert property (
    !pins.oe_a_n[0] |-> pins.dir && pins.en_a) else $error("drives a against dir");
  chk_boot_quiet: assert property (
    !link_ready |-> pins.oe_a_n == 4'hf && !bus_req_local) else $error("active in startup");
  chk_rx_byte: assert property (
    rx_valid |-> !rx_word.last ##1 !rx_valid) else $error("bad receive pulse");
  cover property ($rose(bus_req_local));
  cover property (rx_valid);
  cover property (!tx_ready);
endmodule : ihd_assertions
bind ihd_host ihd_assertions u_ihd_assertions (.core_clk(core_clk), .arst_n(arst_n),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word), .link_ready(link_ready),
  .bus_req_local(bus_req_local), .bus_req_remote(bus_req_remote), .pins(pins));

// [ihd_iso.sv]
// isolator model with four reversible channels
`timescale 1ns/1ps
module ihd_iso
  import ihd_pkg::*;
#(
  parameter bit INVERTING = 1'b0
) (
  input wire ihd_pkg::ihd_pins_t pins,
  input wire logic [3:0] far_b_in,
  output logic [3:0] chan_a_in,
  output wire [3:0] b_out,
  output logic iso_dir
);
  logic [3:0] inv;
  assign inv = {4{INVERTING}};
  // inertial delay swallows pulses shorter than the filter, like the deglitch path
  assign #(PROP_NS) chan_a_in = (!pins.dir && pins.en_a) ? far_b_in ^ inv : ~pins.out_a;
  assign #(PROP_NS) b_out = (pins.dir && pins.en_b && pins.oe_a_n == 4'h0) ? pins.out_a ^ inv : 4'hz;
  assign #(PROP_NS) iso_dir = pins.dir;
endmodule : ihd_iso

// [tb.sv]
// testbench for the half-duplex host with an isolator model
`timescale 1ns/1ps
module tb;
  import ihd_pkg::*;
  logic core_clk = 0;
  logic arst_n = 0;
  logic tx_valid = 0;
  logic bus_req_remote = 0;
  logic tx_ready, rx_valid, busy, link_ready, bus_req_local, iso_dir;
  ihd_word_t tx_word = '0;
  ihd_word_t rx_word;
  ihd_pins_t pins;
  logic [3:0] chan_a_in;
  logic [3:0] far_b_in = 4'h6;
  wire [3:0] b_out;
  int err_count = 0;
  int n_tests = 0;
  int i;
  // settle wait kept at 8 so a nibble outlasts the channel filter
  ihd_host #(.STARTUP_WAIT(20), .SETTLE_WAIT(8)) u_ihd_host (.core_clk(core_clk),
    .arst_n(arst_n), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
    .rx_word(rx_word), .rx_valid(rx_valid), .busy(busy), .link_ready(link_ready),
    .bus_req_local(bus_req_local), .bus_req_remote(bus_req_remote), .pins(pins),
    .chan_a_in(chan_a_in));
  ihd_iso u_ihd_iso (.pins(pins), .far_b_in(far_b_in), .chan_a_in(chan_a_in),
    .b_out(b_out), .iso_dir(iso_dir));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic test_startup;
    chk(link_ready, 0);
    chk(pins.oe_a_n, 4'hf);
    repeat (25) @(negedge core_clk);
    chk(link_ready, 1);
    $display("startup test done");
  endtask : test_startup
  task automatic test_send;
    tx_word = {8'ha5, 1'b1};
    tx_valid = 1;
    @(negedge core_clk);
    tx_valid = 0;
    for (i = 0; i < 80 && b_out !== 4'h5; i++) @(negedge core_clk);
    chk(b_out, 4'h5);
    chk(iso_dir, 1);
    for (i = 0; i < 40 && b_out !== 4'ha; i++) @(negedge core_clk);
    chk(b_out, 4'ha);
    for (i = 0; i < 60 && busy; i++) @(negedge core_clk);
    repeat (10) @(negedge core_clk);
    chk(b_out, 4'hz);
    chk(bus_req_local, 0);
    $display("send test done");
  endtask : test_send
  task automatic test_recv;
    bus_req_remote = 1;
    for (i = 0; i < 80 && !rx_valid; i++) @(negedge core_clk);
    chk(rx_word.data, 8'h66);
    chk(bus_req_local, 0);
    bus_req_remote = 0;
    for (i = 0; i < 60 && busy; i++) @(negedge core_clk);
    $display("receive test done");
  endtask : test_recv
  task automatic test_fill;
    // remote holds the channel, so nothing drains while we fill
    bus_req_remote = 1;
    for (i = 0; i < 16; i++) begin
      tx_word = {i[7:0], i == 15};
      tx_valid = 1;
      @(negedge core_clk);
    end
    tx_valid = 0;
    chk(tx_ready, 0);
    chk(bus_req_local, 0);
    bus_req_remote = 0;
    for (i = 0; i < 2000 && (busy || !tx_ready); i++) @(negedge core_clk);
    chk({busy, tx_ready}, 2'b01);
    $display("fill test done");
  endtask : test_fill
  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1;
    test_startup();
    test_send();
    test_recv();
    test_fill();
    give_verdict();
  end
  initial begin
    #40000;
    err_count++;
    give_verdict();
  end
endmodule : tb
